// ===== shared/tdf_pkg.sv
// Constants, carriers and states shared by the time/date and tachograph framer.
// Assumes one 125 MHz clock and a CAN controller that drains the byte stream.
//
// Functional notes
// - Time/date byte 1: seconds at 0.25 s per count, zero offset.
// - Time/date byte 2: minutes at one minute per count, zero offset.
// - Time/date byte 3: hours at one hour per count, zero offset.
// - Time/date byte 4: month at one month per count, zero offset.
// - Time/date byte 5: day at a quarter day per count, zero offset.
// - Day counts elapsed quarter days in the month; first day midnight is zero.
// - Time/date byte 6: year at one year per count, zero meaning 1985.
// - Time/date bytes 7 and 8, local offsets, are sent as not available.
// - Output shaft speed is sent at 0.125 rpm per count, zero offset.
// - Vehicle speed is sent at 1/256 km/h per count, zero offset.
// - Driver status: both driver working state fields sent as not available.
// - First-driver byte: overspeed, card and time states sent as not available.
// - Second-driver byte: card and time states not available; top bits undefined.
// - Information byte: direction, performance, handling and event not available.
// - Driver status: drive recognition bits 7 and 8 sent as not available.
`default_nettype none

package tdf_pkg;

	// ---------------------------------------------------------------
	// Frame layout
	// ---------------------------------------------------------------
	localparam int         TDF_PAYLOAD_BYTES  = 8;
	localparam logic [2:0] TDF_LAST_BYTE      = 3'h7;
	localparam logic [7:0] TDF_NOT_AVAILABLE  = 8'hFF;
	localparam int         TDF_FIFO_DEPTH     = 32;

	// Byte positions inside the time/date payload, counted from zero.
	localparam int TDF_TD_SECONDS = 0;
	localparam int TDF_TD_MINUTES = 1;
	localparam int TDF_TD_HOURS   = 2;
	localparam int TDF_TD_MONTH   = 3;
	localparam int TDF_TD_DAY     = 4;
	localparam int TDF_TD_YEAR    = 5;

	// Byte positions of the speed fields inside the tachograph tail.
	localparam int TDF_TC_SHAFT_LOW  = 4;
	localparam int TDF_TC_SHAFT_HIGH = 5;
	localparam int TDF_TC_SPEED_LOW  = 6;
	localparam int TDF_TC_SPEED_HIGH = 7;

	// ---------------------------------------------------------------
	// Identifier fields
	// ---------------------------------------------------------------
	localparam logic [2:0] TDF_TD_PRIORITY    = 3'h6;
	localparam logic [2:0] TDF_TC_PRIORITY    = 3'h3;
	localparam logic       TDF_DATA_PAGE      = 1'h0;
	localparam logic       TDF_RESERVED_BIT   = 1'h0;
	localparam logic [7:0] TDF_PDU_FORMAT     = 8'hFE;
	localparam logic [7:0] TDF_TD_PDU_SPECIFIC = 8'hE6;
	localparam logic [7:0] TDF_TC_PDU_SPECIFIC = 8'h6C;

	// ---------------------------------------------------------------
	// Scales and limits
	// ---------------------------------------------------------------
	localparam logic [5:0]  TDF_SECONDS_LIMIT  = 6'h3C;
	localparam logic [5:0]  TDF_MINUTES_LIMIT  = 6'h3C;
	localparam logic [4:0]  TDF_HOURS_LIMIT    = 5'h18;
	localparam logic [4:0]  TDF_HOURS_PER_QUARTER_DAY = 5'h06;
	localparam logic [3:0]  TDF_MONTH_FIRST    = 4'h1;
	localparam logic [3:0]  TDF_MONTH_LAST     = 4'hC;
	localparam logic [4:0]  TDF_DAY_FIRST      = 5'h01;
	localparam logic [11:0] TDF_YEAR_OFFSET    = 12'h7C1;
	localparam logic [11:0] TDF_YEAR_MAX_COUNT = 12'h0FA;

	// ---------------------------------------------------------------
	// Carriers
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [1:0]  quarterSecond; // Quarter of the current second.
		logic [5:0]  seconds;       // 0 to 59.
		logic [5:0]  minutes;       // 0 to 59.
		logic [4:0]  hours;         // 0 to 23.
		logic [3:0]  month;         // 1 to 12.
		logic [4:0]  day;           // Day of month, 1 to 31.
		logic [11:0] year;          // Calendar year.
	} tdf_time_type;

	typedef struct packed {
		logic [15:0] shaftSpeed;   // Output shaft speed, 0.125 rpm per count.
		logic [15:0] vehicleSpeed; // Vehicle speed, 1/256 km/h per count.
	} tdf_tacho_type;

	typedef struct packed {
		logic [28:0] identifier; // Extended CAN identifier of the frame.
		logic        first;      // Set on the first payload byte.
		logic        last;       // Set on the eighth payload byte.
		logic [7:0]  data;       // Payload byte.
	} tdf_beat_type;

	typedef enum logic [0:0] {
		TDF_IDLE = 1'b0,
		TDF_SEND = 1'b1
	} tdf_state_type;

endpackage : tdf_pkg

`default_nettype wire

// ===== core/tdf_framer.sv
// Time/date and tachograph tail framer with its output FIFO.
// Requests come from logic on the same clock; the sink applies back-pressure.
`default_nettype none

// ---------------------------------------------------------------
// Output FIFO
// ---------------------------------------------------------------
module tdf_fifo #(
	parameter int WIDTH = 8,  // Word width.
	parameter int DEPTH = 32  // Words held in the array.
) (
	input  wire logic             clock,    // System clock.
	input  wire logic             reset,    // Synchronous reset, active high.
	input  wire logic [WIDTH-1:0] inData,   // Word to store.
	input  wire logic             inValid,  // Word offered.
	output var  logic             inReady,  // Room in the array.
	output var  logic [WIDTH-1:0] outData,  // Head word, registered.
	output var  logic             outValid, // Head word present.
	input  wire logic             outReady  // Sink takes the head word.
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);

	logic [WIDTH-1:0] store [DEPTH];
	logic [AW-1:0]    writePointer;
	logic [AW-1:0]    readPointer;
	logic [CW-1:0]    count;
	logic [AW-1:0]    next_writePointer;
	logic [AW-1:0]    next_readPointer;
	logic [CW-1:0]    next_count;
	logic [WIDTH-1:0] next_outData;
	logic             next_outValid;
	logic             push;
	logic             pop;

	always_comb begin
		inReady = (count != FULL_COUNT);
		push = inValid && inReady;
		// The output stage refills whenever it is empty or being taken and the array holds a word.
		pop = (count != '0) && (!outValid || outReady);
		next_writePointer = push ? writePointer + AW'(1) : writePointer;
		next_readPointer = pop ? readPointer + AW'(1) : readPointer;
		next_count = count + CW'(push) - CW'(pop);
		next_outData = pop ? store[readPointer] : outData;
		next_outValid = pop ? 1'b1 : (outValid && !outReady);
	end

	always_ff @(posedge clock) begin
		if (push) begin
			store[writePointer] <= inData;
		end
		if (reset) begin
			writePointer <= '0;
			readPointer <= '0;
			count <= '0;
			outData <= '0;
			outValid <= 1'b0;
		end else begin
			writePointer <= next_writePointer;
			readPointer <= next_readPointer;
			count <= next_count;
			outData <= next_outData;
			outValid <= next_outValid;
		end
	end

endmodule // tdf_fifo

// ---------------------------------------------------------------
// Field range check
// ---------------------------------------------------------------
// One copy per calendar field except day, so each checked field's limits sit at one instance.
module tdf_range_check #(
	parameter int WIDTH = 8,   // Field width.
	parameter int FIRST = 0,   // Lowest legal value.
	parameter int LAST  = 255  // Highest legal value.
) (
	input  wire logic [WIDTH-1:0] value,  // Field to check.
	output var  logic             inRange // Value lies between FIRST and LAST.
);
	always_comb begin
		inRange = (int'(value) >= FIRST) && (int'(value) <= LAST);
	end

endmodule // tdf_range_check

// ---------------------------------------------------------------
// Framer
// ---------------------------------------------------------------
module tdf_framer (
	input  wire logic                   clock,           // System clock, 125 MHz.
	input  wire logic                   reset,           // Synchronous reset, active high.
	input  wire tdf_pkg::tdf_time_type  timeDate,        // Current calendar time.
	input  wire tdf_pkg::tdf_tacho_type tacho,           // Current speeds.
	input  wire logic [7:0]             sourceAddress,   // Own network address.
	input  wire logic                   timeDateRequest, // Pulse: a node asked for time/date.
	input  wire logic                   tachoRequest,    // Pulse: send a tachograph tail.
	output var  tdf_pkg::tdf_beat_type  beat,            // Outgoing payload byte.
	output var  logic                   beatValid,       // Beat offered.
	input  wire logic                   beatReady        // Controller takes the beat.
);
	import tdf_pkg::*;

	tdf_state_type state;
	tdf_state_type next_state;
	logic [TDF_PAYLOAD_BYTES-1:0][7:0] payload;
	logic [TDF_PAYLOAD_BYTES-1:0][7:0] next_payload;
	logic [TDF_PAYLOAD_BYTES-1:0][7:0] timeBytes;
	logic [TDF_PAYLOAD_BYTES-1:0][7:0] tachoBytes;
	logic [28:0]   identifier;
	logic [28:0]   next_identifier;
	logic [2:0]    byteIndex;
	logic [2:0]    next_byteIndex;
	logic          pendingTime;
	logic          pendingTacho;
	logic          next_pendingTime;
	logic          next_pendingTacho;
	logic [4:0]    quarterOfDay;
	logic [4:0]    elapsedDays;
	logic [11:0]   yearCount;
	tdf_beat_type  fifoData;
	logic          fifoValid;
	logic          fifoReady;
	logic          secondsValid;
	logic          minutesValid;
	logic          hoursValid;
	logic          monthValid;
	logic          yearValid;

	// ---------------------------------------------------------------
	// Field range checks
	// ---------------------------------------------------------------
	tdf_range_check #(
		.WIDTH ($bits(timeDate.seconds)),
		.FIRST (0),
		.LAST  (int'(TDF_SECONDS_LIMIT) - 1)
	) secondsCheck (
		.value   (timeDate.seconds),
		.inRange (secondsValid)
	);

	tdf_range_check #(
		.WIDTH ($bits(timeDate.minutes)),
		.FIRST (0),
		.LAST  (int'(TDF_MINUTES_LIMIT) - 1)
	) minutesCheck (
		.value   (timeDate.minutes),
		.inRange (minutesValid)
	);

	tdf_range_check #(
		.WIDTH ($bits(timeDate.hours)),
		.FIRST (0),
		.LAST  (int'(TDF_HOURS_LIMIT) - 1)
	) hoursCheck (
		.value   (timeDate.hours),
		.inRange (hoursValid)
	);

	tdf_range_check #(
		.WIDTH ($bits(timeDate.month)),
		.FIRST (int'(TDF_MONTH_FIRST)),
		.LAST  (int'(TDF_MONTH_LAST))
	) monthCheck (
		.value   (timeDate.month),
		.inRange (monthValid)
	);

	tdf_range_check #(
		.WIDTH ($bits(timeDate.year)),
		.FIRST (int'(TDF_YEAR_OFFSET)),
		.LAST  (int'(TDF_YEAR_OFFSET) + int'(TDF_YEAR_MAX_COUNT))
	) yearCheck (
		.value   (timeDate.year),
		.inRange (yearValid)
	);

	// ---------------------------------------------------------------
	// Payload encoding
	// ---------------------------------------------------------------
	// A field whose input is out of range is sent as not available rather
	// than as a wrapped value that a receiver would take for a real time.
	always_comb begin
		timeBytes = {TDF_PAYLOAD_BYTES{TDF_NOT_AVAILABLE}};
		quarterOfDay = timeDate.hours / TDF_HOURS_PER_QUARTER_DAY;
		elapsedDays = timeDate.day - TDF_DAY_FIRST;
		yearCount = timeDate.year - TDF_YEAR_OFFSET;
		if (secondsValid) begin
			timeBytes[TDF_TD_SECONDS] = {timeDate.seconds, timeDate.quarterSecond};
		end
		if (minutesValid) begin
			timeBytes[TDF_TD_MINUTES] = {2'h0, timeDate.minutes};
		end
		if (hoursValid) begin
			timeBytes[TDF_TD_HOURS] = {3'h0, timeDate.hours};
		end
		if (monthValid) begin
			timeBytes[TDF_TD_MONTH] = {4'h0, timeDate.month};
		end
		if (timeDate.day >= TDF_DAY_FIRST && hoursValid) begin
			// Whole elapsed days times four plus the quarter now running.
			timeBytes[TDF_TD_DAY] = {1'h0, elapsedDays, quarterOfDay[1:0]};
		end
		if (yearValid) begin
			timeBytes[TDF_TD_YEAR] = yearCount[7:0];
		end
	end

	always_comb begin
		// Status, both driver bytes and information byte: every field all ones.
		tachoBytes = {TDF_PAYLOAD_BYTES{TDF_NOT_AVAILABLE}};
		tachoBytes[TDF_TC_SHAFT_LOW] = tacho.shaftSpeed[7:0];
		tachoBytes[TDF_TC_SHAFT_HIGH] = tacho.shaftSpeed[15:8];
		tachoBytes[TDF_TC_SPEED_LOW] = tacho.vehicleSpeed[7:0];
		tachoBytes[TDF_TC_SPEED_HIGH] = tacho.vehicleSpeed[15:8];
	end

	// ---------------------------------------------------------------
	// Frame sequencer
	// ---------------------------------------------------------------
	// Time/date wins when both are pending; the tail starts after one idle cycle.
	// The payload is captured when a frame starts so that all eight bytes
	// belong to the same instant even while the FIFO stalls the stream.
	always_comb begin
		next_state = state;
		next_payload = payload;
		next_identifier = identifier;
		next_byteIndex = byteIndex;
		// A request in the cycle its flag is consumed stays pending.
		next_pendingTime = pendingTime || timeDateRequest;
		next_pendingTacho = pendingTacho || tachoRequest;
		fifoValid = (state == TDF_SEND);
		fifoData.identifier = identifier;
		fifoData.first = (byteIndex == 3'h0);
		fifoData.last = (byteIndex == TDF_LAST_BYTE);
		fifoData.data = payload[byteIndex];
		case (state)
			TDF_IDLE: begin
				if (pendingTime) begin
					next_state = TDF_SEND;
					next_payload = timeBytes;
					next_identifier = {TDF_TD_PRIORITY, TDF_RESERVED_BIT, TDF_DATA_PAGE,
						TDF_PDU_FORMAT, TDF_TD_PDU_SPECIFIC, sourceAddress};
					next_byteIndex = 3'h0;
					next_pendingTime = timeDateRequest;
				end else if (pendingTacho) begin
					next_state = TDF_SEND;
					next_payload = tachoBytes;
					next_identifier = {TDF_TC_PRIORITY, TDF_RESERVED_BIT, TDF_DATA_PAGE,
						TDF_PDU_FORMAT, TDF_TC_PDU_SPECIFIC, sourceAddress};
					next_byteIndex = 3'h0;
					next_pendingTacho = tachoRequest;
				end
			end
			TDF_SEND: begin
				if (fifoReady) begin
					if (byteIndex == TDF_LAST_BYTE) begin
						next_state = TDF_IDLE;
					end else begin
						next_byteIndex = byteIndex + 3'h1;
					end
				end
			end
			default: begin
				next_state = TDF_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			state <= TDF_IDLE;
			payload <= '0;
			identifier <= '0;
			byteIndex <= 3'h0;
			pendingTime <= 1'b0;
			pendingTacho <= 1'b0;
		end else begin
			state <= next_state;
			payload <= next_payload;
			identifier <= next_identifier;
			byteIndex <= next_byteIndex;
			pendingTime <= next_pendingTime;
			pendingTacho <= next_pendingTacho;
		end
	end

	// ---------------------------------------------------------------
	// Output buffer
	// ---------------------------------------------------------------
	// Its registered head drives the outputs; a full FIFO stalls the sequencer.
	tdf_fifo #(
		.WIDTH ($bits(tdf_beat_type)),
		.DEPTH (TDF_FIFO_DEPTH)
	) outputFifo (
		.clock    (clock),
		.reset    (reset),
		.inData   (fifoData),
		.inValid  (fifoValid),
		.inReady  (fifoReady),
		.outData  (beat),
		.outValid (beatValid),
		.outReady (beatReady)
	);

endmodule // tdf_framer

`default_nettype wire

// ===== testbench/tdf_framer_checker.sv
// Concurrent checks on the framer's ports; bound to every framer instance.
// Assumes sourceAddress is held steady while a frame is in flight.
`default_nettype none
module tdf_framer_checker (
	input wire logic                   clock,           // System clock.
	input wire logic                   reset,           // Synchronous reset.
	input wire tdf_pkg::tdf_time_type  timeDate,        // Calendar time.
	input wire tdf_pkg::tdf_tacho_type tacho,           // Speeds.
	input wire logic [7:0]             sourceAddress,   // Own address.
	input wire logic                   timeDateRequest, // Time/date request.
	input wire logic                   tachoRequest,    // Tachograph request.
	input wire tdf_pkg::tdf_beat_type  beat,            // Outgoing byte.
	input wire logic                   beatValid,       // Byte offered.
	input wire logic                   beatReady        // Byte taken.
);
	timeunit 1ns;
	timeprecision 100ps;
	import tdf_pkg::*;
	logic [2:0] idx;
	logic [2:0] next_idx;
	logic       td;
	logic       tc;
	assign td = beat.identifier[15:8] == 8'hE6;
	assign tc = beat.identifier[15:8] == 8'h6C;
	always_comb next_idx = (beatValid && beatReady) ? idx + 3'h1 : idx;
	always_ff @(posedge clock) idx <= reset ? 3'h0 : next_idx;
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	chk_reset_idle: assert property (disable iff (1'b0) reset |=> !beatValid)
		else $error("beat offered after reset");
	chk_beat_hold: assert property (beatValid && !beatReady |=> beatValid && $stable(beat))
		else $error("beat changed while stalled");
	chk_beat_order: assert property (beatValid |-> beat.first == (idx == 3'h0)
		&& beat.last == (idx == 3'h7))
		else $error("frame markers misplaced");
	chk_td_ident: assert property (beatValid && td |-> beat.identifier[28:16]
		== {TDF_TD_PRIORITY, TDF_RESERVED_BIT, TDF_DATA_PAGE, TDF_PDU_FORMAT})
		else $error("time/date identifier wrong");
	chk_src_addr: assert property (beatValid |-> beat.identifier[7:0] == sourceAddress)
		else $error("source address wrong");
	chk_td_tail: assert property (beatValid && td && idx[2:1] == 2'h3 |-> beat.data == 8'hFF)
		else $error("local offset not all ones");
	chk_tc_head: assert property (
		beatValid && tc && !idx[2] |-> beat.data == 8'hFF)
		else $error("status byte not all ones");
	chk_td_answer: assert property (timeDateRequest
		|-> ##[3:300] (beatValid && beat.first && td))
		else $error("time/date request not answered");
endmodule // tdf_framer_checker
bind tdf_framer tdf_framer_checker i_tdf_framer_checker (.clock(clock), .reset(reset),
	.timeDate(timeDate), .tacho(tacho), .sourceAddress(sourceAddress),
	.timeDateRequest(timeDateRequest), .tachoRequest(tachoRequest), .beat(beat),
	.beatValid(beatValid), .beatReady(beatReady));
`default_nettype wire

// ===== testbench/tdf_sink.sv
// Model of the CAN controller that drains the beat stream.
// Mode 0 always takes, 1 stalls at random, 2 stalls throughout.
`default_nettype none
module tdf_sink (
	input  wire logic       clock,     // System clock.
	input  wire logic       reset,     // Synchronous reset.
	input  wire logic [1:0] mode,      // Stall behaviour.
	output var  logic       beatReady  // Takes the head beat.
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] lfsr = 8'hA5;
	always @(posedge clock) begin
		lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
		beatReady <= #1 !reset && (mode == 2'h0 || (mode == 2'h1 && (lfsr[0] | lfsr[2])));
	end
endmodule // tdf_sink
`default_nettype wire

// ===== testbench/tdf_framer_tb_top.sv
// Self-checking bench: random and corner frames, back-pressure, mid-run reset.
// Assumes the checker is bound to the framer in its own file.
`default_nettype none
module tdf_framer_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import tdf_pkg::*;
	logic clock = 1'b0, reset = 1'b1, tdReq = 1'b0, tcReq = 1'b0, beatValid, beatReady;
	logic [7:0] src = 8'h00;
	logic [1:0] mode = 2'h0;
	logic [31:0] rng = 32'hEF17;
	tdf_time_type tim = '0;
	tdf_tacho_type tac = '0;
	tdf_beat_type beat;
	tdf_beat_type rxq[$];
	int miscompares = 0, num_checks = 0;
	initial forever #4 clock = ~clock;
	tdf_framer i_tdf_framer (.clock(clock), .reset(reset), .timeDate(tim), .tacho(tac),
		.sourceAddress(src), .timeDateRequest(tdReq), .tachoRequest(tcReq), .beat(beat),
		.beatValid(beatValid), .beatReady(beatReady));
	tdf_sink i_tdf_sink (.clock(clock), .reset(reset), .mode(mode), .beatReady(beatReady));
	always @(posedge clock) if (!reset && beatValid && beatReady) rxq.push_back(beat);
	function automatic logic [31:0] rnd();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction
	function automatic logic [7:0] exp_byte(logic td, int i);
		if (!td) return i < 4 ? 8'hFF : (i == 4 ? tac.shaftSpeed[7:0] : i == 5 ?
			tac.shaftSpeed[15:8] : i == 6 ? tac.vehicleSpeed[7:0] : tac.vehicleSpeed[15:8]);
		case (i)
			0: return tim.seconds > 59 ? 8'hFF : {tim.seconds, tim.quarterSecond};
			1: return tim.minutes > 59 ? 8'hFF : {2'h0, tim.minutes};
			2: return tim.hours > 23 ? 8'hFF : {3'h0, tim.hours};
			3: return (tim.month == 0 || tim.month > 12) ? 8'hFF : {4'h0, tim.month};
			4: return (tim.day == 0 || tim.hours > 23) ? 8'hFF : 8'((tim.day - 1) * 4 + tim.hours / 6);
			5: return (tim.year < 1985 || tim.year > 2235) ? 8'hFF : 8'(tim.year - 1985);
			default: return 8'hFF;
		endcase
	endfunction
	task automatic check(logic [63:0] seen, logic [63:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		$display("Checks %0d, mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic request(logic td, logic tc);
		@(posedge clock) #1 {tdReq, tcReq} = {td, tc};
		@(posedge clock) #1 {tdReq, tcReq} = 2'b00;
	endtask
	task automatic get_frame(logic td);
		tdf_beat_type b;
		logic [28:0] id;
		for (int n = 0; rxq.size() < 8; n++) begin
			if (n > 2000) begin
				miscompares++;
				conclude();
			end
			@(posedge clock);
		end
		id = td ? {3'h6, 2'b00, 8'hFE, 8'hE6, src}
			: {TDF_TC_PRIORITY, 2'b00, 8'hFE, TDF_TC_PDU_SPECIFIC, src};
		for (int i = 0; i < 8; i++) begin
			b = rxq.pop_front();
			check(64'({b.identifier, b.first, b.last}), 64'({id, i == 0, i == 7}));
			if (td) check(64'(b.data), 64'(exp_byte(1'b1, i)));
			else check(64'(b.data), 64'(exp_byte(1'b0, i)));
		end
	endtask
	task automatic td_case(logic [1:0] q, logic [5:0] s, logic [5:0] m, logic [4:0] h,
		logic [3:0] mo, logic [4:0] d, logic [11:0] y);
		@(posedge clock) #1 tim = '{q, s, m, h, mo, d, y};
		src = 8'(rnd());
		request(1'b1, 1'b0);
		get_frame(1'b1);
	endtask
	initial begin
		repeat (3) @(posedge clock);
		#1 reset = 1'b0;
		td_case(3, 59, 59, 23, 12, 31, 2235);
		td_case(0, 0, 0, 0, 1, 1, 1985);
		td_case(0, 0, 0, 13, 1, 1, 1998);
		td_case(0, 0, 0, 13, 1, 15, 1998);
		td_case(0, 60, 0, 0, 0, 1, 1984);
		for (int k = 0; k < 20; k++) begin
			#1 mode = 2'(k % 2);
			td_case(rnd(), rnd() % 60, rnd() % 60, rnd() % 24, 1 + rnd() % 12, 1 + rnd() % 31,
				1985 + rnd() % 251);
			#1 tac = {16'(rnd()), 16'(rnd())};
			request(1'b0, 1'b1);
			get_frame(1'b0);
		end
		$display("Random frames done");
		request(1'b1, 1'b1);
		get_frame(1'b1);
		get_frame(1'b0);
		$display("Simultaneous requests done");
		#1 mode = 2'h2;
		for (int k = 0; k < 5; k++) begin
			request(!k[0], k[0]);
			repeat (12) @(posedge clock);
		end
		repeat (60) @(posedge clock);
		check(64'(rxq.size()), 64'h0);
		check(64'(beatValid), 64'h1);
		#1 mode = 2'h1;
		for (int k = 0; k < 5; k++) get_frame(!k[0]);
		$display("Full buffer done");
		request(1'b1, 1'b0);
		repeat (5) @(posedge clock);
		#1 reset = 1'b1;
		repeat (3) @(posedge clock);
		#1 reset = 1'b0;
		check(64'(beatValid), 64'h0);
		rxq.delete();
		repeat (30) @(posedge clock);
		check(64'(rxq.size()), 64'h0);
		td_case(1, 30, 7, 6, 2, 28, 2000);
		$display("Mid-run reset done");
		conclude();
	end
endmodule // tdf_framer_tb_top
`default_nettype wire
